// >>> pkg/sbtc_pkg.sv
package sbtc_pkg;
  // register byte addresses (one aligned word each)
  localparam logic [11:0] ADDR_CONTROL  = 12'h000;
  localparam logic [11:0] ADDR_COUNT_LO = 12'h004;
  localparam logic [11:0] ADDR_COUNT_HI = 12'h008;
  localparam logic [11:0] ADDR_IRQ_STAT = 12'h00c;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h010;

  // timer_control field positions
  localparam int BIT_RUN   = 0;
  localparam int BIT_CSRC  = 1;
  localparam int BIT_NSYNC = 2;
  localparam int BIT_TBLO  = 3;
  localparam int BIT_DIVLO = 4;
  localparam int BIT_TBHI  = 6;
  localparam int BIT_WIDE  = 7;

  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET   = 8'h00;
  localparam int         IRQ_OVF_BIT   = 0;

  // instruction cycle is four pclk periods
  localparam int          INSTR_DIV  = 4;
  localparam logic [1:0]  INSTR_LAST = 2'(INSTR_DIV - 1);

  typedef struct packed {
    logic       wide;
    logic       tb_hi;
    logic [1:0] div;
    logic       tb_lo;
    logic       nsync;
    logic       csrc;
    logic       run;
  } sbtc_ctrl_s;

  typedef enum logic [1:0] {SBTC_TIMER, SBTC_SYNC_CNT, SBTC_ASYNC_CNT} sbtc_mode_e;
endpackage

// >>> design/sbtc_timer.sv
`timescale 1ns/1ps
module sbtc_timer #(
  parameter int PRESCALE_W = 3
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        ext_count_in,
  input  wire logic        osc_clk_in,
  input  wire logic        osc_enable,
  input  wire logic [1:0]  port_c_direction,
  input  wire logic [1:0]  port_c_pins,
  output logic [1:0]       port_c_read,
  output logic [1:0]       port_c_oe_n,
  input  wire logic        unit1_event_trig,
  input  wire logic        unit2_event_trig,
  output logic             unit1_uses_main,
  output logic             unit2_uses_main,
  output logic             irq,
  output sbtc_pkg::sbtc_mode_e mode
);
  // the terminal-count decode reads three prescaler bits, so a narrower width cannot work
  if (PRESCALE_W != 3) begin : g_bad_prescale
    $error("prescaler must be three bits for 1:8");
  end

  sbtc_pkg::sbtc_ctrl_s ctrl_ff;
  logic [7:0]            cnt_lo_ff;
  logic [7:0]            cnt_hi_ff;
  logic [7:0]            hi_buf_ff;
  logic [PRESCALE_W-1:0] pre_ff;
  logic [1:0]            instr_ff;
  logic                  sync1_ff;
  logic                  sync2_ff;
  logic                  ext_prev_ff;
  logic                  armed_ff;
  logic                  ovf_ff;
  logic                  mask_ff;
  logic [31:0]           prdata_ff;

  // bus decode; the slave always answers in the first access cycle
  wire acc      = psel & penable;
  wire wr       = acc & pwrite;
  wire rd       = acc & ~pwrite;
  wire hit_ctl  = paddr == sbtc_pkg::ADDR_CONTROL;
  wire hit_lo   = paddr == sbtc_pkg::ADDR_COUNT_LO;
  wire hit_hi   = paddr == sbtc_pkg::ADDR_COUNT_HI;
  wire hit_st   = paddr == sbtc_pkg::ADDR_IRQ_STAT;
  wire hit_msk  = paddr == sbtc_pkg::ADDR_IRQ_MASK;
  wire mapped   = hit_ctl | hit_lo | hit_hi | hit_st | hit_msk;
  wire wr_ctl   = wr & hit_ctl;
  wire wr_lo    = wr & hit_lo;
  wire wr_hi    = wr & hit_hi;
  wire rd_lo    = rd & hit_lo;
  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;
  assign prdata  = prdata_ff;

  // external source: raw pin or oscillator, optionally synchronised
  wire ext_src  = osc_enable ? osc_clk_in : ext_count_in;
  wire ext_lvl  = ctrl_ff.nsync ? ext_src : sync2_ff;
  wire ext_rise = ext_lvl & ~ext_prev_ff & armed_ff;

  // tick source: internal instruction cycle unless external selected
  wire instr_tick = instr_ff == sbtc_pkg::INSTR_LAST;
  wire src_tick   = ctrl_ff.csrc ? ext_rise : instr_tick;

  // prescaler terminal count per divider field
  function automatic logic pre_done(input logic [1:0] sel, input logic [PRESCALE_W-1:0] p);
    unique case (sel)
      2'b00: pre_done = 1'b1;
      2'b01: pre_done = p[0];
      2'b10: pre_done = &p[1:0];
      2'b11: pre_done = &p[2:0];
    endcase
  endfunction

  wire count_en = ctrl_ff.run & src_tick;
  wire inc      = count_en & pre_done(ctrl_ff.div, pre_ff);
  wire [15:0] cnt_now = {cnt_hi_ff, cnt_lo_ff};
  wire [15:0] cnt_inc = cnt_now + 16'h0001;
  wire rollover = inc & (&cnt_now);
  // trigger counts only from units that use this timer as time base
  wire trig_clr = (unit1_event_trig & unit1_uses_main)
                | (unit2_event_trig & unit2_uses_main);

  assign unit1_uses_main = ctrl_ff.tb_hi;
  assign unit2_uses_main = ctrl_ff.tb_hi | ctrl_ff.tb_lo;

  assign mode = !ctrl_ff.csrc ? sbtc_pkg::SBTC_TIMER
              : ctrl_ff.nsync ? sbtc_pkg::SBTC_ASYNC_CNT
              : sbtc_pkg::SBTC_SYNC_CNT;

  // oscillator pins forced to inputs and read as zero
  assign port_c_oe_n = osc_enable ? 2'b11 : port_c_direction;
  assign port_c_read = osc_enable ? 2'b00 : port_c_pins;

  assign irq = ovf_ff & mask_ff;

  // next count: bus write wins over counting, trigger over both
  logic [7:0] nxt_lo;
  logic [7:0] nxt_hi;
  always_comb begin
    nxt_lo = cnt_lo_ff;
    nxt_hi = cnt_hi_ff;
    if (inc) begin
      nxt_lo = cnt_inc[7:0];
      nxt_hi = cnt_inc[15:8];
    end
    if (wr_lo) begin
      nxt_lo = pwdata[7:0];
      if (ctrl_ff.wide) nxt_hi = hi_buf_ff;
    end
    if (wr_hi && !ctrl_ff.wide) nxt_hi = pwdata[7:0];
    if (trig_clr) begin
      nxt_lo = 8'h00;
      nxt_hi = 8'h00;
    end
  end

  // read mux; high address shows the buffer in wide mode
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    if (hit_ctl) rd_byte = ctrl_ff;
    if (hit_lo)  rd_byte = cnt_lo_ff;
    if (hit_hi)  rd_byte = ctrl_ff.wide ? hi_buf_ff : cnt_hi_ff;
    if (hit_st)  rd_byte = {7'h00, ovf_ff};
    if (hit_msk) rd_byte = {7'h00, mask_ff};
  end

  // read data registered in setup so it is valid at the access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata_ff <= 32'h0000_0000;
    else if (psel && !penable && !pwrite) prdata_ff <= {24'h00_0000, rd_byte};
  end

  // control and interrupt registers; overflow set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= sbtc_pkg::CONTROL_RESET;
      mask_ff <= 1'b0;
      ovf_ff  <= 1'b0;
    end else begin
      if (wr_ctl) ctrl_ff <= pwdata[7:0];
      if (wr && hit_msk) mask_ff <= pwdata[sbtc_pkg::IRQ_OVF_BIT];
      if (rollover) ovf_ff <= 1'b1;
      else if (wr && hit_st && pwdata[sbtc_pkg::IRQ_OVF_BIT]) ovf_ff <= 1'b0;
    end
  end

  // count bytes and high buffer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_lo_ff <= sbtc_pkg::COUNT_RESET;
      cnt_hi_ff <= sbtc_pkg::COUNT_RESET;
      hi_buf_ff <= sbtc_pkg::COUNT_RESET;
    end else begin
      cnt_lo_ff <= nxt_lo;
      cnt_hi_ff <= nxt_hi;
      if (wr_hi && ctrl_ff.wide) hi_buf_ff <= pwdata[7:0];
      else if (rd_lo && ctrl_ff.wide) hi_buf_ff <= cnt_hi_ff;
    end
  end

  // prescaler: only low-byte writes and trigger clear it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pre_ff <= '0;
    else if (wr_lo || trig_clr) pre_ff <= '0;
    else if (count_en) pre_ff <= pre_ff + 1'b1;
  end

  // instruction-cycle divider, free running
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) instr_ff <= 2'b00;
    else instr_ff <= instr_ff + 2'b01;
  end

  // synchroniser, edge history and falling-edge arm
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff    <= 1'b0;
      sync2_ff    <= 1'b0;
      ext_prev_ff <= 1'b0;
      armed_ff    <= 1'b0;
    end else begin
      sync1_ff    <= ext_src;
      sync2_ff    <= sync1_ff;
      ext_prev_ff <= ext_lvl;
      // a rising edge counts only after a falling edge was seen since enable
      if (!ctrl_ff.csrc || !ctrl_ff.run) armed_ff <= 1'b0;
      else if (!ext_lvl && ext_prev_ff) armed_ff <= 1'b1;
    end
  end
endmodule

// >>> verification/sbtc_monitor.sv
`timescale 1ns/1ps
// port-level checker: control fields, shared pins and interrupt level
module sbtc_monitor (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        osc_enable,
  input wire logic [1:0]  port_c_pins,
  input wire logic [1:0]  port_c_read,
  input wire logic [1:0]  port_c_oe_n,
  input wire logic        unit1_uses_main,
  input wire logic        unit2_uses_main,
  input wire logic        irq,
  input wire sbtc_pkg::sbtc_mode_e mode
);
  // completed writes; iw is wide on purpose so irq_hold_a never fires falsely
  wire cw = psel & penable & pwrite & (paddr == sbtc_pkg::ADDR_CONTROL);
  wire iw = psel & penable & pwrite & (paddr >= sbtc_pkg::ADDR_IRQ_STAT);
  wire mw = iw & (paddr == sbtc_pkg::ADDR_IRQ_MASK) & ~pwdata[0];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  osc_pins_a: assert property (osc_enable |-> port_c_read == 2'h0 && port_c_oe_n == 2'h3)
    else $error("pins not released");
  pin_pass_a: assert property (!osc_enable |-> port_c_read == port_c_pins)
    else $error("pin read wrong");
  unit_share_a: assert property (unit1_uses_main |-> unit2_uses_main)
    else $error("time base split wrong");
  tb_write_a: assert property (cw |=> unit1_uses_main == $past(pwdata[6])
    && unit2_uses_main == ($past(pwdata[6]) | $past(pwdata[3]))) else $error("time base wrong");
  mode_write_a: assert property (cw |=> mode == (!$past(pwdata[1]) ? sbtc_pkg::SBTC_TIMER
    : $past(pwdata[2]) ? sbtc_pkg::SBTC_ASYNC_CNT : sbtc_pkg::SBTC_SYNC_CNT))
    else $error("mode wrong");
  mode_hold_a: assert property (!cw |=> $stable(mode)) else $error("mode moved");
  irq_hold_a: assert property (irq && !iw |=> irq) else $error("flag not sticky");
  irq_mask_a: assert property (mw |=> !irq) else $error("masked irq high");
  cover property (cw && pwdata[7]);
  cover property ($rose(irq));
  cover property (osc_enable && mode == sbtc_pkg::SBTC_ASYNC_CNT);
endmodule

bind sbtc_timer sbtc_monitor i_sbtc_monitor (.*);

// >>> verification/sbtc_partner.sv
`timescale 1ns/1ps
// far side: count pin, companion oscillator and capture/compare triggers
module sbtc_partner (
  input  wire logic pclk,
  output logic      ext_count_in,
  output logic      osc_clk_in,
  output logic      unit1_event_trig,
  output logic      unit2_event_trig
);
  // count and oscillator lines idle high so a fall must precede the first counted rise; triggers idle low
  initial begin
    ext_count_in = 1'h1;
    osc_clk_in = 1'h1;
    unit1_event_trig = 1'h0;
    unit2_event_trig = 1'h0;
  end
  // n slow low-high cycles on the pin or the oscillator line
  task automatic pulse(input logic osc, input int n);
    repeat (n) begin
      if (osc) osc_clk_in <= 1'h0;
      else ext_count_in <= 1'h0;
      repeat (4) @(posedge pclk);
      if (osc) osc_clk_in <= 1'h1;
      else ext_count_in <= 1'h1;
      repeat (4) @(posedge pclk);
    end
  endtask
  // compare match in special-event mode gives a one-cycle pulse
  task automatic fire(input int u);
    @(posedge pclk);
    unit1_event_trig <= (u == 1);
    unit2_event_trig <= (u == 2);
    @(posedge pclk);
    unit1_event_trig <= 1'h0;
    unit2_event_trig <= 1'h0;
  endtask
endmodule

// >>> verification/sbtc_timer_test.sv
`timescale 1ns/1ps
module sbtc_timer_test;
  localparam logic [11:0] CT = sbtc_pkg::ADDR_CONTROL;
  localparam logic [11:0] LO = sbtc_pkg::ADDR_COUNT_LO;
  localparam logic [11:0] HI = sbtc_pkg::ADDR_COUNT_HI;
  localparam logic [11:0] ST = sbtc_pkg::ADDR_IRQ_STAT;
  localparam logic [11:0] MK = sbtc_pkg::ADDR_IRQ_MASK;
  logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic        osc_enable = 1'h0, pready, pslverr, irq, ext_count_in, osc_clk_in;
  logic        unit1_event_trig, unit2_event_trig, unit1_uses_main, unit2_uses_main;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, q;
  logic        e;
  logic [1:0]  port_c_direction = 2'h1, port_c_pins = 2'h2, port_c_read, port_c_oe_n;
  sbtc_pkg::sbtc_mode_e mode;
  int          miscompares = 0, checks_done = 0;
  sbtc_timer i_sbtc_timer (.*);
  sbtc_partner i_sbtc_partner (.*);
  initial forever #12.5 pclk = ~pclk;
  // one apb transfer; read data lands in q
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected at %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic summarize();
    if (miscompares == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // each ratio over 65 cycles, then the stopped count must hold
  task automatic t_div();
    logic [31:0] h;
    for (int d = 0; d < 4; d++) begin
      apb(LO, 1'h1, 8'h00);
      apb(CT, 1'h1, 32'(d << 4) | 8'h05);
      repeat (62) @(posedge pclk);
      apb(CT, 1'h1, 8'h00);
      apb(LO, 1'h0, 8'h00);
      chk(q, q inside {[(16 >> d) - 1:(16 >> d) + 1]} ? q : 16 >> d);
      h = q;
      repeat (20) @(posedge pclk);
      apb(LO, 1'h0, 8'h00);
      chk(q, h);
    end
  endtask
  // buffered high byte: reads and writes only through the buffer
  task automatic t_wide();
    apb(CT, 1'h1, 8'h80);
    apb(HI, 1'h1, 8'h12);
    apb(LO, 1'h0, 8'h00);
    apb(HI, 1'h0, 8'h00);
    chk(q, 8'h00);
    apb(HI, 1'h1, 8'h12);
    apb(LO, 1'h1, 8'h34);
    apb(HI, 1'h1, 8'h56);
    apb(LO, 1'h0, 8'h00);
    chk(q, 8'h34);
    apb(HI, 1'h0, 8'h00);
    chk(q, 8'h12);
    apb(CT, 1'h1, 8'h00);
    apb(HI, 1'h0, 8'h00);
    chk(q, 8'h12);
  endtask
  // rollover from fff8 sets the sticky flag; mask and clear
  task automatic t_ovf();
    apb(HI, 1'h1, 8'hff);
    apb(LO, 1'h1, 8'hf8);
    apb(MK, 1'h1, 8'h01);
    apb(CT, 1'h1, 8'h01);
    repeat (60) @(posedge pclk);
    apb(CT, 1'h1, 8'h00);
    apb(ST, 1'h0, 8'h00);
    chk({q[0], irq}, 2'h3);
    apb(MK, 1'h1, 8'h00);
    #1 chk(irq, 1'h0);
    apb(MK, 1'h1, 8'h01);
    #1 chk(irq, 1'h1);
    apb(ST, 1'h1, 8'h01);
    #1 chk(irq, 1'h0);
  endtask
  // trigger clears the count only where this timer is the time base
  task automatic t_trig();
    for (int s = 0; s < 3; s++)
      for (int u = 1; u < 3; u++) begin
        apb(CT, 1'h1, s == 0 ? 8'h40 : s == 1 ? 8'h08 : 8'h00);
        apb(LO, 1'h1, 8'h55);
        i_sbtc_partner.fire(u);
        apb(LO, 1'h0, 8'h00);
        chk(q, s == 0 || (s == 1 && u == 2) ? 8'h00 : 8'h55);
      end
  endtask
  // three edges: synced pin, then unsynced oscillator
  task automatic t_ext();
    for (int i = 0; i < 2; i++) begin
      osc_enable <= i[0];
      apb(LO, 1'h1, 8'h00);
      apb(CT, 1'h1, 32'(i * 4 + 3));
      i_sbtc_partner.pulse(i[0], 3);
      apb(CT, 1'h1, 8'h00);
      apb(LO, 1'h0, 8'h00);
      chk(q, 8'h03);
    end
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    apb(CT, 1'h0, 8'h00);
    chk(q, 8'h00);
    chk(e, 1'h0);
    apb(12'h020, 1'h0, 8'h00);
    chk(q, 8'h00);
    chk(e, 1'h1);
    t_div();
    t_wide();
    t_ovf();
    t_trig();
    t_ext();
    summarize();
  end
  // hang guard, far beyond the roughly 660 cycles needed
  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    summarize();
  end
endmodule
